// ===== design/mode_ctrl.sv
// operating mode, system control register and port function selection
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_regs.svh"
module mode_ctrl (
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [2:0] mode_select_pins, // mode straps
    input wire logic [3:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write strobe
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic all_areas_8bit, // bus ctrl: every area 8-bit
    input wire logic any_area_16bit, // bus ctrl: some area 16-bit
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic rom_enable, // on-chip ROM active
    output logic external_bus_enable, // external space open
    output logic onchip_ram_enable, // on-chip RAM active
    output logic xfer_ctrl_addr_mode, // 1 short, 0 full address
    output logic bus_16bit, // data bus 16 bits wide
    output logic addr_ports_fixed, // ports D,E,F forced to address
    output logic addr_ports_by_dir, // ports D,E,F address per direction
    output logic data_hi_port_fixed, // port H forced to data
    output logic data_ports_by_dir, // ports H,I data per direction
    output logic data_lo_port_used, // port I part of data bus
    output logic bus_ctrl_ports // parts of A,B as bus control
);
    // =====================================================================
    // operating mode
    mode_ctrl_pkg::op_mode_t mode_reg;
    logic mode_valid_reg;
    mode_ctrl_pkg::op_mode_t mode_next;
    logic ext_mode;
    logic rom_on;

    // decode of straps; undefined codes fall back to single-chip mode 7
    always_comb begin
        unique case (mode_select_pins)
            `PINS_MODE2: mode_next = mode_ctrl_pkg::MODE_2;
            `PINS_MODE4: mode_next = mode_ctrl_pkg::MODE_4;
            `PINS_MODE5: mode_next = mode_ctrl_pkg::MODE_5;
            `PINS_MODE6: mode_next = mode_ctrl_pkg::MODE_6;
            `PINS_MODE7: mode_next = mode_ctrl_pkg::MODE_7;
            default: mode_next = mode_ctrl_pkg::MODE_7;
        endcase
    end

    // straps sampled on clock while reset is held and on the first edge after
    // release; frozen afterwards, so a strap glitch later cannot switch mode
    logic latched_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            latched_reg <= 1'b0;
        end else begin
            latched_reg <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !latched_reg) begin
            mode_reg <= mode_next;
        end
    end
    assign mode_valid_reg = latched_reg;

    // mode 2 maps onto mode 7 for everything this block controls
    assign ext_mode = (mode_reg == mode_ctrl_pkg::MODE_4) || (mode_reg == mode_ctrl_pkg::MODE_5)
        || (mode_reg == mode_ctrl_pkg::MODE_6);
    assign rom_on = (mode_reg != mode_ctrl_pkg::MODE_4) && (mode_reg != mode_ctrl_pkg::MODE_5);

    // =====================================================================
    // system control register fields
    logic ext_sw_reg;
    logic ram_reg;
    logic xfer_reg;
    logic wr_sysctl_hi;
    logic wr_sysctl_lo;
    logic bus_req;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_sysctl_hi = bus_req && wb_we_i && (wb_adr_i == `SYSCTL_OFFSET) && wb_sel_i[1];
    assign wr_sysctl_lo = bus_req && wb_we_i && (wb_adr_i == `SYSCTL_OFFSET) && wb_sel_i[0];

    // software bus enable, used only in single-chip modes; caller must keep the
    // external bus idle before clearing it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ext_sw_reg <= 1'b0;
        end else if (wr_sysctl_hi) begin
            ext_sw_reg <= wb_dat_i[`SYSCTL_EXT_BIT];
        end
    end

    // RAM enable; no guard against clearing mid-access, software owns that
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ram_reg <= `RAM_RESET;
        end else if (wr_sysctl_hi) begin
            ram_reg <= wb_dat_i[`SYSCTL_RAM_BIT];
        end
    end

    // transfer controller address mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xfer_reg <= `XFER_RESET;
        end else if (wr_sysctl_lo) begin
            xfer_reg <= wb_dat_i[`SYSCTL_XFER_BIT];
        end
    end

    logic ext_eff;
    assign ext_eff = ext_mode ? 1'b1 : ext_sw_reg;

    // register image; bits 7..2 zero, bit 0 one, writes to them dropped
    logic [15:0] sysctl_rd;
    always_comb begin
        sysctl_rd = 16'h0000;
        sysctl_rd[15:11] = `SYSCTL_FIXED_HI;
        sysctl_rd[`SYSCTL_ROM_BIT] = rom_on;
        sysctl_rd[`SYSCTL_EXT_BIT] = ext_eff;
        sysctl_rd[`SYSCTL_RAM_BIT] = ram_reg;
        sysctl_rd[`SYSCTL_XFER_BIT] = xfer_reg;
        sysctl_rd[`SYSCTL_RSV0_BIT] = 1'b1;
    end

    // =====================================================================
    // wishbone slave: one wait state, ack one cycle, unmapped reads zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `SYSCTL_OFFSET: wb_dat_o <= {16'h0000, sysctl_rd};
                    `MODESTAT_OFFSET: wb_dat_o <= {29'h0, mode_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =====================================================================
    // bus width: mode 4 starts wide and narrows; 5 and 6 start narrow and widen
    logic wide;
    always_comb begin
        unique case (mode_reg)
            mode_ctrl_pkg::MODE_4: wide = !all_areas_8bit;
            mode_ctrl_pkg::MODE_5,
            mode_ctrl_pkg::MODE_6: wide = any_area_16bit;
            default: wide = any_area_16bit && ext_sw_reg;
        endcase
    end

    // =====================================================================
    // registered outputs; port roles follow the per-mode pin table
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rom_enable <= 1'b0;
            external_bus_enable <= 1'b0;
            onchip_ram_enable <= 1'b0;
            xfer_ctrl_addr_mode <= 1'b1;
            bus_16bit <= 1'b0;
            addr_ports_fixed <= 1'b0;
            addr_ports_by_dir <= 1'b0;
            data_hi_port_fixed <= 1'b0;
            data_ports_by_dir <= 1'b0;
            data_lo_port_used <= 1'b0;
            bus_ctrl_ports <= 1'b0;
        end else begin
            rom_enable <= rom_on;
            external_bus_enable <= ext_eff;
            onchip_ram_enable <= ram_reg;
            xfer_ctrl_addr_mode <= xfer_reg;
            bus_16bit <= wide;
            addr_ports_fixed <= !rom_on;
            addr_ports_by_dir <= rom_on && ext_eff;
            data_hi_port_fixed <= ext_mode;
            data_ports_by_dir <= !ext_mode && ext_sw_reg;
            data_lo_port_used <= ext_eff && wide;
            bus_ctrl_ports <= ext_eff;
        end
    end

    // =====================================================================
    // assertions
    a_rom_bit_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mode_valid_reg |-> sysctl_rd[10] == ((mode_reg != mode_ctrl_pkg::MODE_4)
        && (mode_reg != mode_ctrl_pkg::MODE_5)))
        else $error("rom bit disagrees with mode");
    a_ext_fixed_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 (ext_mode && mode_valid_reg) |-> ##1 external_bus_enable)
        else $error("bus enable not held in extended mode");
    a_ext_write_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_sysctl_hi && !ext_mode) |=> sysctl_rd[9] == $past(wb_dat_i[9]))
        else $error("bus enable write lost in single-chip mode");
    a_ram_follows_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_sysctl_hi |=> ##1 onchip_ram_enable == $past(wb_dat_i[8], 2))
        else $error("ram enable output wrong");
    a_fixed_bits_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sysctl_rd[7:2] == 6'h00 && sysctl_rd[0])
        else $error("fixed bits read wrong");
    a_xfer_mode_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_sysctl_lo |=> ##1 xfer_ctrl_addr_mode == $past(wb_dat_i[1], 2))
        else $error("transfer mode output wrong");
    a_mode4_narrow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (mode_reg == mode_ctrl_pkg::MODE_4 && all_areas_8bit) |=> !bus_16bit)
        else $error("mode 4 did not narrow");
    a_mode56_widen: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ((mode_reg == mode_ctrl_pkg::MODE_5 || mode_reg == mode_ctrl_pkg::MODE_6)
        && any_area_16bit) |=> bus_16bit && data_lo_port_used)
        else $error("mode 5 or 6 did not widen");
    a_mode_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        latched_reg |=> $stable(mode_reg))
        else $error("mode changed after reset");
    a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // =====================================================================
    // step sequences shared by the checks below
    // first sampled edge after the straps were frozen
    sequence s_release;
        !latched_reg ##1 latched_reg;
    endsequence
    // upper lane alone written, lower lane alone written
    sequence s_write_hi_only;
        latched_reg && wr_sysctl_hi && !wr_sysctl_lo;
    endsequence
    sequence s_write_lo_only;
        latched_reg && wr_sysctl_lo && !wr_sysctl_hi;
    endsequence
    // read of either mapped register taken
    sequence s_read_ctl;
        bus_req && !wb_we_i && (wb_adr_i == `SYSCTL_OFFSET);
    endsequence
    sequence s_read_mode;
        bus_req && !wb_we_i && (wb_adr_i == `MODESTAT_OFFSET);
    endsequence
    // write taken anywhere outside the control register
    sequence s_write_elsewhere;
        bus_req && wb_we_i && (wb_adr_i != `SYSCTL_OFFSET);
    endsequence

    // =====================================================================
    // mode, port role, register and bus checks
    // fields leave reset with their fixed start values
    a_release_values: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_release |-> ram_reg && xfer_reg && (ext_eff == ext_mode))
        else $error("control fields wrong after reset");

    // straps seen on the release edge pick the mode
    a_strap_mode2: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_release ##0 ($past(mode_select_pins) == `PINS_MODE2))
        |-> mode_reg == mode_ctrl_pkg::MODE_2)
        else $error("strap code for mode 2 not decoded");
    a_strap_mode4: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_release ##0 ($past(mode_select_pins) == `PINS_MODE4))
        |-> mode_reg == mode_ctrl_pkg::MODE_4)
        else $error("strap code for mode 4 not decoded");
    a_strap_mode5: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_release ##0 ($past(mode_select_pins) == `PINS_MODE5))
        |-> mode_reg == mode_ctrl_pkg::MODE_5)
        else $error("strap code for mode 5 not decoded");
    a_strap_mode6: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_release ##0 ($past(mode_select_pins) == `PINS_MODE6))
        |-> mode_reg == mode_ctrl_pkg::MODE_6)
        else $error("strap code for mode 6 not decoded");
    a_strap_mode7: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_release ##0 ($past(mode_select_pins) == `PINS_MODE7))
        |-> mode_reg == mode_ctrl_pkg::MODE_7)
        else $error("strap code for mode 7 not decoded");

    // ROM-less modes drive address, data and control pins outright
    a_rom_off_ext: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && ((mode_reg == mode_ctrl_pkg::MODE_4)
        || (mode_reg == mode_ctrl_pkg::MODE_5)))
        |=> !rom_enable && addr_ports_fixed && data_hi_port_fixed && bus_ctrl_ports)
        else $error("ROM-less mode port roles wrong");

    // ROM modes never force the address ports
    a_rom_on_int: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && (mode_reg != mode_ctrl_pkg::MODE_4)
        && (mode_reg != mode_ctrl_pkg::MODE_5))
        |=> rom_enable && !addr_ports_fixed)
        else $error("ROM mode port roles wrong");

    // mode 6: address by direction setting, port H data
    a_mode6_roles: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && (mode_reg == mode_ctrl_pkg::MODE_6))
        |=> addr_ports_by_dir && data_hi_port_fixed && !data_ports_by_dir)
        else $error("mode 6 port roles wrong");

    // single-chip modes keep every port general until bus enable is set
    a_single_closed: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && !ext_sw_reg && ((mode_reg == mode_ctrl_pkg::MODE_7)
        || (mode_reg == mode_ctrl_pkg::MODE_2)))
        |=> !external_bus_enable && !addr_ports_by_dir && !data_ports_by_dir
        && !bus_16bit && !bus_ctrl_ports)
        else $error("single-chip mode not closed");
    a_single_open: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && ext_sw_reg && ((mode_reg == mode_ctrl_pkg::MODE_7)
        || (mode_reg == mode_ctrl_pkg::MODE_2)))
        |=> external_bus_enable && addr_ports_by_dir && data_ports_by_dir
        && bus_ctrl_ports)
        else $error("single-chip mode not opened by bus enable");

    // extended modes read bus enable as one whatever was written
    a_ext_reads_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (latched_reg && ext_mode) |-> sysctl_rd[`SYSCTL_EXT_BIT])
        else $error("bus enable reads zero in extended mode");

    // read data carries the image sampled when the request was taken
    a_ctl_read_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_read_ctl |=> wb_ack_o && (wb_dat_o == {16'h0000, $past(sysctl_rd)}))
        else $error("control read data wrong");
    a_mode_read_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_read_mode |=> wb_ack_o && (wb_dat_o == {29'h0, $past(mode_reg)}))
        else $error("mode read data wrong");

    // one answer per request, none without one
    a_ack_answers: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged");
    a_no_stray_ack: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !bus_req |=> !wb_ack_o)
        else $error("acknowledge without request");

    // byte lanes stay apart; other addresses touch nothing
    a_lane_lo_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_write_lo_only |=> $stable(ram_reg) && $stable(ext_sw_reg))
        else $error("lower lane write changed upper fields");
    a_lane_hi_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_write_hi_only |=> $stable(xfer_reg))
        else $error("upper lane write changed lower field");
    a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_write_elsewhere |=> $stable(ram_reg) && $stable(ext_sw_reg) && $stable(xfer_reg))
        else $error("unmapped write changed a field");

    // bus width start points per mode
    a_mode4_wide: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (mode_reg == mode_ctrl_pkg::MODE_4 && !all_areas_8bit) |=> bus_16bit && data_lo_port_used)
        else $error("mode 4 not wide");
    a_mode4_lo_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (mode_reg == mode_ctrl_pkg::MODE_4 && all_areas_8bit) |=> !data_lo_port_used)
        else $error("mode 4 narrow still uses port I");
    a_mode56_narrow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ((mode_reg == mode_ctrl_pkg::MODE_5 || mode_reg == mode_ctrl_pkg::MODE_6)
        && !any_area_16bit) |=> !bus_16bit && !data_lo_port_used)
        else $error("mode 5 or 6 not narrow");
endmodule
`default_nettype wire

// ===== design/mode_ctrl_pkg.sv
// types for the mode control block
package mode_ctrl_pkg;
    typedef enum logic [2:0] {MODE_2, MODE_4, MODE_5, MODE_6, MODE_7} op_mode_t;
endpackage

// ===== design/mode_ctrl_regs.svh
// register offsets, field positions, reset values and mode codes for the mode control block
// Notes on behaviour
// - bit 10 reads 1 when ROM enabled
// - extended modes hold bus enable at one
// - single-chip bus enable resets 0, writable
// - RAM enable bit resets to one
// - bits 7..2 read zero, write zero
// - transfer mode bit resets one, short mode
// - bit 0 resets one, reads one
// - mode 2 behaves as mode 7
// - mode 4 ROM off, 16-bit start
// - mode 4 all areas 8-bit narrows bus
// - mode 5 ROM off, 8-bit start
// - modes 5,6 any 16-bit area widens bus
// - mode 6 ROM on, address by direction
// - mode 7 ROM on, all ports I/O
// - mode 7 bus enable opens external space
// - mode pins map 010,100,101,110,111
`ifndef MODE_CTRL_REGS_SVH
`define MODE_CTRL_REGS_SVH
// =====================================================================
// register map
`define SYSCTL_OFFSET 4'h0
`define MODESTAT_OFFSET 4'h4
`define SYSCTL_ROM_BIT 10
`define SYSCTL_EXT_BIT 9
`define SYSCTL_RAM_BIT 8
`define SYSCTL_XFER_BIT 1
`define SYSCTL_RSV0_BIT 0
`define SYSCTL_FIXED_HI 5'h1B
`define SYSCTL_MACS_BIT 13
`define SYSCTL_FETCH_BIT 11
`define RAM_RESET 1'h1
`define XFER_RESET 1'h1
// =====================================================================
// mode pin codes
`define PINS_MODE2 3'h2
`define PINS_MODE4 3'h4
`define PINS_MODE5 3'h5
`define PINS_MODE6 3'h6
`define PINS_MODE7 3'h7
`endif

// ===== tb/area_width_model.sv
// bus controller stand-in that reports the access width of the areas
`timescale 1ns/1ps
`default_nettype none
module area_width_model (
    input wire logic [7:0] area_cfg, // one bit per area, high = 16-bit
    output logic all_areas_8bit, // no area set to 16-bit
    output logic any_area_16bit // at least one 16-bit area
);
    // =====================================================
    // width summary
    // combinational, so a width change reaches the block without extra lag
    assign all_areas_8bit = ~|area_cfg;
    assign any_area_16bit = |area_cfg;
endmodule
`default_nettype wire

// ===== tb/operating_mode_bus_config_tb_top.sv
// testbench for the mode control block: modes, control register, port roles
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_regs.svh"
module operating_mode_bus_config_tb_top;
    // =====================================================
    // signals
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] pins = 3'h7;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [7:0] area_cfg = 8'h00;
    logic [7:0] e;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rom_enable, external_bus_enable, onchip_ram_enable, xfer_ctrl_addr_mode;
    logic bus_16bit, addr_ports_fixed, addr_ports_by_dir, data_hi_port_fixed;
    logic all_areas_8bit, any_area_16bit;
    logic data_ports_by_dir, data_lo_port_used, bus_ctrl_ports;
    logic [7:0] outs;
    int err_count = 0;
    int samples_checked = 0;
    // per mode: straps, status code, outputs {rom,ext,ram,xfer,b16,fix,bydir,hifix}
    logic [2:0] tp [5] = '{`PINS_MODE2, `PINS_MODE4, `PINS_MODE5, `PINS_MODE6, `PINS_MODE7};
    mode_ctrl_pkg::op_mode_t tm [5] = '{mode_ctrl_pkg::MODE_2, mode_ctrl_pkg::MODE_4,
        mode_ctrl_pkg::MODE_5, mode_ctrl_pkg::MODE_6, mode_ctrl_pkg::MODE_7};
    logic [7:0] tout [5] = '{8'hB0, 8'h7D, 8'h75, 8'hF3, 8'hB0};
    assign outs = {rom_enable, external_bus_enable, onchip_ram_enable, xfer_ctrl_addr_mode,
        bus_16bit, addr_ports_fixed, addr_ports_by_dir, data_hi_port_fixed};
    always #12.5 clk_sys = ~clk_sys;
    // =====================================================
    // instances
    area_width_model area_width_model_inst (.area_cfg(area_cfg),
        .all_areas_8bit(all_areas_8bit), .any_area_16bit(any_area_16bit));
    mode_ctrl mode_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n), .mode_select_pins(pins),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .all_areas_8bit(all_areas_8bit), .any_area_16bit(any_area_16bit),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rom_enable(rom_enable),
        .external_bus_enable(external_bus_enable), .onchip_ram_enable(onchip_ram_enable),
        .xfer_ctrl_addr_mode(xfer_ctrl_addr_mode), .bus_16bit(bus_16bit),
        .addr_ports_fixed(addr_ports_fixed), .addr_ports_by_dir(addr_ports_by_dir),
        .data_hi_port_fixed(data_hi_port_fixed), .data_ports_by_dir(data_ports_by_dir),
        .data_lo_port_used(data_lo_port_used), .bus_ctrl_ports(bus_ctrl_ports));
    // =====================================================
    // tasks
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: pins %b want %b", $time, got, exp);
        end
    endtask
    // classic single cycle; held until ack is seen at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("unexpected at %0t: no ack", $time);
        end
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hF, 32'h0);
        chk(rd, exp);
    endtask
    function automatic logic [31:0] exp_ctl(input logic r, x, m, t);
        return {16'h0000, 5'h1B, r, x, m, 6'h00, t, 1'b1};
    endfunction
    // =====================================================
    // tests
    initial begin
        for (int i = 0; i < 5; i++) begin
            e = tout[i];
            // mode 4 bus controller starts with all areas 16-bit
            reset_n <= 1'b0;
            pins <= tp[i];
            area_cfg <= (i == 1) ? 8'hFF : 8'h00;
            repeat (20) @(posedge clk_sys);
            reset_n <= 1'b1;
            repeat (2) @(posedge clk_sys);
            pins <= 3'h0; // straps move after reset; mode must not
            repeat (2) @(posedge clk_sys);
            rdchk(`MODESTAT_OFFSET, {29'h0, tm[i]});
            rdchk(`SYSCTL_OFFSET, exp_ctl(e[7], e[6], 1'b1, 1'b1));
            chk_pin(outs, e);
            chk_pin({5'h0, bus_ctrl_ports, data_lo_port_used, data_ports_by_dir}, {5'h0, e[6], e[3], 1'b0});
            bus(1'b1, `SYSCTL_OFFSET, 4'h1, 32'h0000_00FC);
            rdchk(`SYSCTL_OFFSET, exp_ctl(e[7], e[6], 1'b1, 1'b0));
            bus(1'b1, `SYSCTL_OFFSET, 4'h2, 32'h0000_0200);
            rdchk(`SYSCTL_OFFSET, exp_ctl(e[7], 1'b1, 1'b0, 1'b0));
            repeat (2) @(posedge clk_sys);
            chk_pin({7'h0, addr_ports_by_dir}, {7'h0, ~e[2]});
            chk_pin({6'h0, bus_ctrl_ports, data_ports_by_dir}, {6'h0, 1'b1, ~e[0]});
            bus(1'b1, `SYSCTL_OFFSET, 4'h2, 32'h0);
            rdchk(`SYSCTL_OFFSET, exp_ctl(e[7], e[6], 1'b0, 1'b0));
            area_cfg <= 8'h00;
            repeat (4) @(posedge clk_sys);
            chk_pin({7'h0, bus_16bit}, 8'h00);
            area_cfg <= 8'h01;
            repeat (4) @(posedge clk_sys);
            chk_pin({7'h0, bus_16bit}, {7'h0, e[6]});
            chk_pin({7'h0, data_lo_port_used}, {7'h0, e[6]});
        end
        // unmapped place: write ignored, read zero, control bits untouched
        bus(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF);
        rdchk(4'h8, 32'h0);
        rdchk(`SYSCTL_OFFSET, exp_ctl(1'b1, 1'b0, 1'b0, 1'b0));
        final_report();
    end
    // hang guard, far beyond the few hundred cycles the tests take
    initial begin
        #400000;
        err_count++;
        $display("unexpected at %0t: watchdog", $time);
        final_report();
    end
endmodule
`default_nettype wire
